// File: src/axis_speed_position_params.sv
// file holds the apb register bank for one axis
// assumes: the motion core is same-clock logic driving the state inputs
`timescale 1ns/1ps
module axis_speed_position_params
#(
	parameter logic [15:0] ID_CODE = 16'h5A5A // arbitrary identity value
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        moving,
	input  wire logic        pulser_mode,
	input  wire logic        move_done,
	input  wire logic        out_pulse,
	input  wire logic [13:0] present_speed,
	input  wire logic [3:0]  zphase_count,
	input  wire logic [23:0] auto_point,
	output logic             start_pulse,
	output logic             halt_pulse,
	output logic             queue_full,
	output logic [6:0]       operation_mode_field,
	output logic             slowdown_method_sel,
	output axis_params_pkg::param_set_t active_q,
	output logic [15:0]      eff_decel_rate,
	output logic [12:0]      eff_ascurve,
	output logic [12:0]      eff_dscurve,
	output logic [25:0]      pulse_rate,
	output logic [31:0]      interp_feed_used,
	output logic             feed_override
);

	// ****************************************
	// storage
	// ****************************************
	axis_params_pkg::param_set_t pre_q;
	logic                        pend_q;
	logic                        id_armed_q;
	logic [3:0]                  zphase_count_setting;
	logic [31:0]                 ctl_q;
	logic [31:0]                 remaining_pulses;
	logic [31:0]                 slow_rb;
	logic [31:0]                 slow_view;
	logic [31:0]                 rd_d;
	logic                        wr_en;
	logic                        rd_en;
	logic                        known;
	logic                        cmd_wr;
	logic [7:0]                  cmd;
	logic [13:0]                 half_span;

	assign wr_en = psel && penable && pwrite && !pready;
	assign rd_en = psel && penable && !pwrite && !pready;
	assign cmd_wr = wr_en && paddr == axis_params_pkg::OFS_COMMAND;
	assign cmd = pwdata[7:0];
	assign operation_mode_field = ctl_q[6:0];
	assign slowdown_method_sel = ctl_q[axis_params_pkg::CTL_SLOWSEL];
	assign zphase_count_setting = ctl_q[axis_params_pkg::CTL_ZSET_LSB +: 4];
	assign half_span = 14'((active_q.top - active_q.start) >> 1);

	// ****************************************
	// apb handshake: one wait state, answer on second access edge
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= axis_params_pkg::RESET_VAL;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !known;
			if (rd_en)
				prdata <= known ? rd_d : axis_params_pkg::RESET_VAL;
		end
	end

	// ****************************************
	// control word and start/halt commands
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl_q <= axis_params_pkg::RESET_VAL;
		else if (wr_en && paddr == axis_params_pkg::OFS_CONTROL)
			ctl_q <= pwdata & 32'h0000_F17F;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_pulse <= 1'b0;
			halt_pulse  <= 1'b0;
		end
		else
		begin
			start_pulse <= cmd_wr && cmd == axis_params_pkg::CMD_GO;
			halt_pulse  <= cmd_wr && cmd == axis_params_pkg::CMD_HALT;
		end
	end

	// id shows on the first mult read after the monitor command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			id_armed_q <= 1'b0;
		else if (cmd_wr && cmd == axis_params_pkg::CMD_ID_MONITOR)
			id_armed_q <= 1'b1;
		else if (rd_en && paddr == axis_params_pkg::OFS_MULT)
			id_armed_q <= 1'b0;
	end

	// ****************************************
	// pre-registers: written by offset or by the start-speed pre-write command code
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_q <= '0;
		else if (wr_en && !(pend_q && moving))
		begin
			// queue locked once a pending set is latched during motion
			unique case (paddr)
				axis_params_pkg::OFS_FEED_PRE:    pre_q.feed    <= pwdata;
				axis_params_pkg::OFS_START_PRE:   pre_q.start   <= pwdata[13:0];
				axis_params_pkg::OFS_TOP_PRE:     pre_q.top     <= pwdata[13:0];
				axis_params_pkg::OFS_ACCEL_PRE:   pre_q.accel   <= pwdata[15:0];
				axis_params_pkg::OFS_DECEL_PRE:   pre_q.decel   <= pwdata[15:0];
				axis_params_pkg::OFS_MULT_PRE:    pre_q.mult    <= pwdata[11:0];
				axis_params_pkg::OFS_SLOW_PRE:    pre_q.slow    <= pwdata[23:0];
				axis_params_pkg::OFS_INTERP_PRE:  pre_q.interp  <= pwdata;
				axis_params_pkg::OFS_ASCURVE_PRE: pre_q.ascurve <= pwdata[12:0];
				axis_params_pkg::OFS_DSCURVE_PRE: pre_q.dscurve <= pwdata[12:0];
				axis_params_pkg::OFS_COMMAND:
					if (cmd == axis_params_pkg::CMD_START_PRE_WR)
						pre_q.start <= pwdata[21:8];
				default: ;
			endcase
		end
	end

	// start during motion latches the pre set as pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_q <= 1'b0;
		else if (halt_pulse)
			pend_q <= 1'b0;
		else if (start_pulse && moving)
			pend_q <= 1'b1;
		else if (move_done)
			pend_q <= 1'b0;
	end
	assign queue_full = pend_q;

	// ****************************************
	// working registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			active_q <= '0;
		else if (move_done && pend_q)
			active_q <= pre_q;
		else if (wr_en)
		begin
			// stopped pre writes fall through at once
			unique case (paddr)
				axis_params_pkg::OFS_FEED, axis_params_pkg::OFS_FEED_PRE:
					if (paddr == axis_params_pkg::OFS_FEED || !moving)
						active_q.feed <= pwdata;
				axis_params_pkg::OFS_START, axis_params_pkg::OFS_START_PRE:
					if (paddr == axis_params_pkg::OFS_START || !moving)
						active_q.start <= pwdata[13:0];
				axis_params_pkg::OFS_TOP, axis_params_pkg::OFS_TOP_PRE:
					if (paddr == axis_params_pkg::OFS_TOP || !moving)
						active_q.top <= pwdata[13:0];
				axis_params_pkg::OFS_ACCEL, axis_params_pkg::OFS_ACCEL_PRE:
					if (paddr == axis_params_pkg::OFS_ACCEL || !moving)
						active_q.accel <= pwdata[15:0];
				axis_params_pkg::OFS_DECEL, axis_params_pkg::OFS_DECEL_PRE:
					if (paddr == axis_params_pkg::OFS_DECEL || !moving)
						active_q.decel <= pwdata[15:0];
				axis_params_pkg::OFS_MULT, axis_params_pkg::OFS_MULT_PRE:
					if (paddr == axis_params_pkg::OFS_MULT || !moving)
						active_q.mult <= pwdata[11:0];
				axis_params_pkg::OFS_SLOW, axis_params_pkg::OFS_SLOW_PRE:
					if (paddr == axis_params_pkg::OFS_SLOW || !moving)
						active_q.slow <= pwdata[23:0];
				axis_params_pkg::OFS_INTERP, axis_params_pkg::OFS_INTERP_PRE:
					if (paddr == axis_params_pkg::OFS_INTERP || !moving)
						active_q.interp <= pwdata;
				axis_params_pkg::OFS_ASCURVE, axis_params_pkg::OFS_ASCURVE_PRE:
					if (paddr == axis_params_pkg::OFS_ASCURVE || !moving)
						active_q.ascurve <= pwdata[12:0];
				axis_params_pkg::OFS_DSCURVE, axis_params_pkg::OFS_DSCURVE_PRE:
					if (paddr == axis_params_pkg::OFS_DSCURVE || !moving)
						active_q.dscurve <= pwdata[12:0];
				axis_params_pkg::OFS_COMMAND:
					if (cmd == axis_params_pkg::CMD_START_WR ||
					    (cmd == axis_params_pkg::CMD_START_PRE_WR && !moving))
						active_q.start <= pwdata[21:8];
				default: ;
			endcase
		end
	end

	// ****************************************
	// derived values for the motion core
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			eff_decel_rate   <= '0;
			eff_ascurve      <= '0;
			eff_dscurve      <= '0;
			pulse_rate       <= '0;
			interp_feed_used <= '0;
			feed_override    <= 1'b0;
		end
		else
		begin
			eff_decel_rate <= (active_q.decel == '0) ? active_q.accel
			                                         : active_q.decel;
			eff_ascurve <= (active_q.ascurve == '0) ? 13'(half_span)
			                                        : active_q.ascurve;
			eff_dscurve <= (active_q.dscurve == '0) ? 13'(half_span)
			                                        : active_q.dscurve;
			// product of 14-bit step and 12-bit multiplier fits 26 bits
			pulse_rate <= present_speed * active_q.mult;
			interp_feed_used <= (operation_mode_field == axis_params_pkg::MODE_LIN_CONT ||
			                     operation_mode_field == axis_params_pkg::MODE_LIN_INC)
			                    ? active_q.interp : '0;
			feed_override <= wr_en && moving && paddr == axis_params_pkg::OFS_FEED &&
			                 operation_mode_field == axis_params_pkg::MODE_INC_POS;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	axis_remaining_counter #(
		.WIDTH (32)
	) u_remain (
		.pclk       (pclk),
		.presetn    (presetn),
		.clear      (wr_en && (paddr == axis_params_pkg::OFS_FEED ||
		             paddr == axis_params_pkg::OFS_FEED_PRE)),
		.load       (start_pulse && !moving),
		.load_value (active_q.feed),
		.pulse      (out_pulse),
		.count      (remaining_pulses)
	);

	axis_slowdown_calc u_slow (
		.pclk         (pclk),
		.presetn      (presetn),
		.manual       (slowdown_method_sel),
		.setting      (active_q.slow),
		.auto_point   (auto_point),
		.readback     (slow_rb),
		.setting_view (slow_view)
	);

	// ****************************************
	// read mux
	// ****************************************
	always_comb
	begin
		known = 1'b1;
		rd_d  = axis_params_pkg::RESET_VAL;
		unique case (paddr)
			axis_params_pkg::OFS_FEED_PRE:    rd_d = pre_q.feed;
			axis_params_pkg::OFS_START_PRE:   rd_d = 32'(pre_q.start);
			axis_params_pkg::OFS_TOP_PRE:     rd_d = 32'(pre_q.top);
			axis_params_pkg::OFS_ACCEL_PRE:   rd_d = 32'(pre_q.accel);
			axis_params_pkg::OFS_DECEL_PRE:   rd_d = 32'(pre_q.decel);
			axis_params_pkg::OFS_MULT_PRE:    rd_d = 32'(pre_q.mult);
			axis_params_pkg::OFS_SLOW_PRE:
				rd_d = slowdown_method_sel ? {8'h00, pre_q.slow}
				                           : {{8{pre_q.slow[23]}}, pre_q.slow};
			axis_params_pkg::OFS_INTERP_PRE:  rd_d = pre_q.interp;
			axis_params_pkg::OFS_ASCURVE_PRE: rd_d = 32'(pre_q.ascurve);
			axis_params_pkg::OFS_DSCURVE_PRE: rd_d = 32'(pre_q.dscurve);
			axis_params_pkg::OFS_FEED:        rd_d = active_q.feed;
			axis_params_pkg::OFS_START:       rd_d = 32'(active_q.start);
			axis_params_pkg::OFS_TOP:         rd_d = 32'(active_q.top);
			axis_params_pkg::OFS_ACCEL:       rd_d = 32'(active_q.accel);
			axis_params_pkg::OFS_DECEL:       rd_d = 32'(active_q.decel);
			axis_params_pkg::OFS_MULT:
				rd_d = {id_armed_q ? ID_CODE : 16'h0000, 4'h0, active_q.mult};
			axis_params_pkg::OFS_SLOW:        rd_d = slow_view;
			axis_params_pkg::OFS_INTERP:      rd_d = active_q.interp;
			axis_params_pkg::OFS_ASCURVE:     rd_d = 32'(active_q.ascurve);
			axis_params_pkg::OFS_DSCURVE:     rd_d = 32'(active_q.dscurve);
			axis_params_pkg::OFS_REMAIN:      rd_d = remaining_pulses;
			axis_params_pkg::OFS_SPEED_RB:
				rd_d = {12'h000,
				        moving ? zphase_count : zphase_count_setting, 2'b00,
				        !moving ? 14'h0000 :
				        pulser_mode ? active_q.top : present_speed};
			axis_params_pkg::OFS_SLOW_RB:     rd_d = slow_rb;
			axis_params_pkg::OFS_CONTROL:     rd_d = ctl_q;
			axis_params_pkg::OFS_COMMAND:
				rd_d = (cmd == axis_params_pkg::CMD_START_PRE_RD) ? 32'(pre_q.start) :
				       32'(active_q.start);
			axis_params_pkg::OFS_STATUS:      rd_d = {30'h0, moving, pend_q};
			default:                          known = 1'b0;
		endcase
	end

	// ****************************************
	// checks
	// ****************************************
	a_decel_fallback: assert property (@(posedge pclk) disable iff (!presetn)
		active_q.decel == '0 && $stable(active_q) |=> eff_decel_rate == $past(active_q.accel))
		else $error("zero decel rate did not fall back");

	a_top_override: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && moving && paddr == axis_params_pkg::OFS_TOP && !(move_done && pend_q)
		|=> active_q.top == $past(pwdata[13:0]))
		else $error("top speed override not applied");

	a_pre_through: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && !moving && !pend_q && paddr == axis_params_pkg::OFS_ACCEL_PRE
		|=> active_q.accel == $past(pwdata[15:0]))
		else $error("stopped pre write not copied");

	a_pre_queued: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && moving && !move_done && paddr == axis_params_pkg::OFS_ACCEL_PRE
		|=> $stable(active_q.accel))
		else $error("moving pre write reached working register");

	a_feed_clears: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == axis_params_pkg::OFS_FEED |=> remaining_pulses == 32'h0000_0000)
		else $error("feed write did not clear remaining count");

	a_id_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == axis_params_pkg::OFS_MULT |=> !id_armed_q [*2])
		else $error("id stayed armed after read");

	a_speed_stopped: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && !moving && paddr == axis_params_pkg::OFS_SPEED_RB
		|=> prdata[13:0] == 14'h0000 && prdata[31:20] == 12'h000)
		else $error("speed readback not zero when stopped");

	a_interp_gate: assert property (@(posedge pclk) disable iff (!presetn)
		operation_mode_field == axis_params_pkg::MODE_INC_POS |=> interp_feed_used == '0)
		else $error("interp feed used outside interpolation");

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one wait state");

endmodule

// File: src/axis_params_pkg.sv
// package: register map, field layout and command codes for the axis
// speed/position parameter bank
// assumes: apb byte addressing, 32-bit data, one register per word
package axis_params_pkg;

	// ****************************************
	// register byte offsets (word index * 4)
	// ****************************************
	localparam logic [7:0] OFS_FEED_PRE       = 8'h00;
	localparam logic [7:0] OFS_START_PRE      = 8'h04;
	localparam logic [7:0] OFS_TOP_PRE        = 8'h08;
	localparam logic [7:0] OFS_ACCEL_PRE      = 8'h0C;
	localparam logic [7:0] OFS_DECEL_PRE      = 8'h10;
	localparam logic [7:0] OFS_MULT_PRE       = 8'h14;
	localparam logic [7:0] OFS_SLOW_PRE       = 8'h18;
	localparam logic [7:0] OFS_INTERP_PRE     = 8'h20;
	localparam logic [7:0] OFS_ASCURVE_PRE    = 8'h24;
	localparam logic [7:0] OFS_DSCURVE_PRE    = 8'h28;
	localparam logic [7:0] OFS_FEED           = 8'h40;
	localparam logic [7:0] OFS_START          = 8'h44;
	localparam logic [7:0] OFS_TOP            = 8'h48;
	localparam logic [7:0] OFS_ACCEL          = 8'h4C;
	localparam logic [7:0] OFS_DECEL          = 8'h50;
	localparam logic [7:0] OFS_MULT           = 8'h54;
	localparam logic [7:0] OFS_SLOW           = 8'h58;
	localparam logic [7:0] OFS_INTERP         = 8'h60;
	localparam logic [7:0] OFS_ASCURVE        = 8'h64;
	localparam logic [7:0] OFS_DSCURVE        = 8'h68;
	localparam logic [7:0] OFS_REMAIN         = 8'h80;
	localparam logic [7:0] OFS_SPEED_RB       = 8'h84;
	localparam logic [7:0] OFS_SLOW_RB        = 8'h88;
	localparam logic [7:0] OFS_CONTROL        = 8'h90;
	localparam logic [7:0] OFS_COMMAND        = 8'h94;
	localparam logic [7:0] OFS_STATUS         = 8'h98;

	// ****************************************
	// host command codes on the command word
	// ****************************************
	localparam logic [7:0] CMD_START_PRE_WR   = 8'h81;
	localparam logic [7:0] CMD_START_PRE_RD   = 8'hC1;
	localparam logic [7:0] CMD_START_WR       = 8'h91;
	localparam logic [7:0] CMD_START_RD       = 8'hD1;
	localparam logic [7:0] CMD_ID_MONITOR     = 8'h03;
	localparam logic [7:0] CMD_GO             = 8'h40;
	localparam logic [7:0] CMD_HALT           = 8'h49;

	// ****************************************
	// operation modes and field widths
	// ****************************************
	localparam logic [6:0] MODE_INC_POS       = 7'h41;
	localparam logic [6:0] MODE_LIN_CONT      = 7'h62;
	localparam logic [6:0] MODE_LIN_INC       = 7'h63;
	localparam int SPEED_W    = 14;
	localparam int RATE_W     = 16;
	localparam int MULT_W     = 12;
	localparam int SLOW_W     = 24;
	localparam int SCURVE_W   = 13;
	localparam int ZCNT_W     = 4;
	localparam int CTL_MODE_LSB  = 0;
	localparam int CTL_SLOWSEL   = 8;
	localparam int CTL_ZSET_LSB  = 12;
	localparam logic [31:0] RESET_VAL = 32'h0000_0000;

	// one transfer slot of the two-stage parameter queue
	typedef struct packed {
		logic [31:0]         feed;
		logic [SPEED_W-1:0]  start;
		logic [SPEED_W-1:0]  top;
		logic [RATE_W-1:0]   accel;
		logic [RATE_W-1:0]   decel;
		logic [MULT_W-1:0]   mult;
		logic [SLOW_W-1:0]   slow;
		logic [31:0]         interp;
		logic [SCURVE_W-1:0] ascurve;
		logic [SCURVE_W-1:0] dscurve;
	} param_set_t;

endpackage

// File: src/axis_remaining_counter.sv
// remaining pulse counter: load on start while stopped, count down per output pulse
// assumes: pulse strobes are one-cycle, same clock
`timescale 1ns/1ps
module axis_remaining_counter
#(
	parameter int WIDTH = 32
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clear,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             pulse,
	output logic      [WIDTH-1:0] count
);

	// load beats pulse; clear from a feed write beats both
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else if (clear)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (pulse && count != '0)
			count <= count - WIDTH'(1);
	end

	a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
		(!clear && !load && pulse && count != '0) |=> count == $past(count) - 1)
		else $error("remaining count did not step down");

endmodule

// File: src/axis_slowdown_calc.sv
// slow-down readback: auto point plus signed offset, or manual value
// assumes: auto point is supplied by the ramp logic, same clock
`timescale 1ns/1ps
module axis_slowdown_calc
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        manual,
	input  wire logic [23:0] setting,
	input  wire logic [23:0] auto_point,
	output logic      [31:0] readback,
	output logic      [31:0] setting_view
);

	logic [23:0] sum;

	// offset is two's complement; wrap is kept in 24 bits
	assign sum = auto_point + setting;

	// auto mode shows sign-extended sum, manual the stored count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			readback <= '0;
		else if (manual)
			readback <= {8'h00, setting};
		else
			readback <= {{8{sum[23]}}, sum};
	end

	// upper byte follows bit 23 in auto mode, zero in manual
	always_comb
	begin
		if (manual)
			setting_view = {8'h00, setting};
		else
			setting_view = {{8{setting[23]}}, setting};
	end

	a_manual_view: assert property (@(posedge pclk) disable iff (!presetn)
		manual && $stable(setting) && $stable(manual)
		|=> readback == {8'h00, $past(setting)})
		else $error("manual slow-down readback mismatch");

endmodule

// File: sim/apb_host.sv
// host model: apb master issuing register reads and writes
// assumes: one clock, requests issued just after a rising edge
`timescale 1ns/1ps
module apb_host
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rd_q;
	logic        err_q;
	logic        tmo_q;
	// idle bus at time zero
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		tmo_q = 1'b0;
	end
	// one transfer, held until pready is sampled, bounded wait
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		tmo_q = (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// File: sim/axis_speed_position_params_test.sv
// bench: register model compared with every mapped-register read of the axis bank
// assumes: apb_host model drives the bus, motion inputs driven here
`timescale 1ns/1ps
module axis_speed_position_params_test;
	logic        pclk, presetn, moving, out_pulse, pulser_mode;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, v;
	logic [13:0] spd;
	logic [3:0]  zc;
	logic [15:0] eff_decel_rate;
	logic [12:0] eff_ascurve;
	logic [25:0] pulse_rate;
	logic [31:0] interp_feed_used;
	axis_params_pkg::param_set_t active_q;
	logic [31:0] mdl [logic [7:0]];
	int          err_count, total_checks, seed;
	// identity value given to the design, arbitrary
	localparam logic [15:0] ID_VAL = 16'h3C96;
	apb_host h (.*);
	axis_speed_position_params #(.ID_CODE(ID_VAL)) i_dut (.*,
		.move_done(1'b0), .present_speed(spd), .zphase_count(zc),
		.auto_point(24'h00_0000), .start_pulse(), .halt_pulse(),
		.queue_full(), .operation_mode_field(), .slowdown_method_sel(),
		.eff_dscurve(), .feed_override());
	// 100 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic end_sim();
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e || h.tmo_q)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
		if (h.tmo_q)
			end_sim();
	endtask
	// a write that never sees pready ends the run as a failure
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		h.xfer(1'b1, a, d);
		if (h.tmo_q)
		begin
			err_count++;
			$display("BAD pready_timeout exp 1 got 0");
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		h.xfer(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg_%h", a), mdl[a], h.rd_q);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		seed = 21;
		{presetn, moving, out_pulse, pulser_mode, spd, zc} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		v = ($random(seed) & 32'h0000_00FF) | 32'h0000_0010;
		wr(axis_params_pkg::OFS_FEED_PRE, v);
		mdl[axis_params_pkg::OFS_FEED] = v;
		mdl[axis_params_pkg::OFS_REMAIN] = 32'h0000_0000;
		rd(axis_params_pkg::OFS_FEED);
		rd(axis_params_pkg::OFS_REMAIN);
		wr(axis_params_pkg::OFS_COMMAND,
			{24'h00_0000, axis_params_pkg::CMD_GO});
		repeat (3)
		begin
			@(posedge pclk);
			out_pulse <= 1'b1;
			@(posedge pclk);
			out_pulse <= 1'b0;
		end
		mdl[axis_params_pkg::OFS_REMAIN] = v - 32'h0000_0003;
		rd(axis_params_pkg::OFS_REMAIN);
		wr(axis_params_pkg::OFS_FEED, v);
		mdl[axis_params_pkg::OFS_REMAIN] = 32'h0000_0000;
		rd(axis_params_pkg::OFS_REMAIN);
		wr(axis_params_pkg::OFS_MULT, 32'hFFFF_0123);
		mdl[axis_params_pkg::OFS_MULT] = 32'h0000_0123;
		rd(axis_params_pkg::OFS_MULT);
		// identity shows once after the monitor command, then zero
		wr(axis_params_pkg::OFS_COMMAND,
			{24'h00_0000, axis_params_pkg::CMD_ID_MONITOR});
		mdl[axis_params_pkg::OFS_MULT] = {ID_VAL, 16'h0123};
		rd(axis_params_pkg::OFS_MULT);
		mdl[axis_params_pkg::OFS_MULT] = 32'h0000_0123;
		rd(axis_params_pkg::OFS_MULT);
		// mode 41h, z count setting 5, slow-down method auto then manual
		for (int m = 0; m < 2; m++)
		begin
			wr(axis_params_pkg::OFS_CONTROL, 32'h0000_5041 | (m << 8));
			wr(axis_params_pkg::OFS_SLOW, 32'h0080_0001);
			mdl[axis_params_pkg::OFS_SLOW] =
				m ? 32'h0080_0001 : 32'hFF80_0001;
			rd(axis_params_pkg::OFS_SLOW);
		end
		mdl[axis_params_pkg::OFS_SLOW_RB] = 32'h0080_0001;
		rd(axis_params_pkg::OFS_SLOW_RB);
		v = ($random(seed) & 32'h0000_FFFF) | 32'h0000_0001;
		wr(axis_params_pkg::OFS_ACCEL_PRE, v);
		wr(axis_params_pkg::OFS_DECEL_PRE, 32'h0000_0000);
		@(posedge pclk);
		chk("eff_decel_rate", v, {16'h0000, eff_decel_rate});
		spd <= 14'($random(seed));
		zc <= 4'($random(seed));
		moving <= 1'b1;
		@(posedge pclk);
		mdl[axis_params_pkg::OFS_SPEED_RB] = {12'h000, zc, 2'b00, spd};
		rd(axis_params_pkg::OFS_SPEED_RB);
		// pre write during motion stays queued, working value kept
		wr(axis_params_pkg::OFS_ACCEL_PRE, 32'h0000_0055);
		mdl[axis_params_pkg::OFS_ACCEL] = v;
		mdl[axis_params_pkg::OFS_ACCEL_PRE] = 32'h0000_0055;
		rd(axis_params_pkg::OFS_ACCEL);
		rd(axis_params_pkg::OFS_ACCEL_PRE);
		wr(axis_params_pkg::OFS_TOP, 32'h0000_1234);
		@(posedge pclk);
		chk("top", 32'h0000_1234, {18'h0_0000, active_q.top});
		v = 32'(spd) * 32'h0000_0123;
		chk("pulse_rate", v, {6'h00, pulse_rate});
		pulser_mode <= 1'b1;
		mdl[axis_params_pkg::OFS_SPEED_RB] =
			{12'h000, zc, 2'b00, 14'h1234};
		rd(axis_params_pkg::OFS_SPEED_RB);
		pulser_mode <= 1'b0;
		moving <= 1'b0;
		h.xfer(1'b0, 8'h3C, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, {31'h0, h.err_q});
		chk("unmapped_rdata", 32'h0000_0000, h.rd_q);
		mdl[axis_params_pkg::OFS_SPEED_RB] = 32'h0005_0000;
		rd(axis_params_pkg::OFS_SPEED_RB);
		wr(axis_params_pkg::OFS_COMMAND,
			{10'h000, 14'h3FFF, axis_params_pkg::CMD_START_WR});
		mdl[axis_params_pkg::OFS_START] = 32'h0000_3FFF;
		rd(axis_params_pkg::OFS_START);
		wr(axis_params_pkg::OFS_COMMAND,
			{10'h000, 14'h0001, axis_params_pkg::CMD_START_PRE_WR});
		mdl[axis_params_pkg::OFS_START] = 32'h0000_0001;
		rd(axis_params_pkg::OFS_START);
		// zero s-curve setting stands for half of top minus start
		v = (32'h0000_1234 - 32'h0000_0001) >> 1;
		chk("eff_ascurve", v, {19'h0_0000, eff_ascurve});
		// main-axis feed is passed on only in modes 62h and 63h
		v = $random(seed) & 32'h7FFF_FFFF;
		wr(axis_params_pkg::OFS_INTERP, v);
		wr(axis_params_pkg::OFS_CONTROL, 32'h0000_0062);
		@(posedge pclk);
		chk("interp_feed_used", v, interp_feed_used);
		end_sim();
	end
endmodule
